// [hdl/eesu_map.vh]
`ifndef EESU_MAP_VH
`define EESU_MAP_VH

// ----------------------------------------
// register set selection codes
// ----------------------------------------
`define EESU_SEL_SEC_END  2'h0
`define EESU_SEL_SEC_ERR  2'h1
`define EESU_SEL_PRI_END  2'h2
`define EESU_SEL_PRI_ERR  2'h3

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define EESU_SET_COUNT    4
`define EESU_EV_WIDTH     8
`define EESU_EV_RESET     8'h00
`define EESU_MASK_RESET   8'h00
`define EESU_SUM_RESET    4'h0

`endif

// [hdl/eesu_top.v]
`timescale 1ns/1ns
`include "eesu_map.vh"

// Functional notes
// - registers exist only in native language mode
// - separate sets for first and second channel
// - summary bit 3: primary error masked
// - summary bit 2: primary end masked
// - summary bit 1: secondary error masked
// - summary bit 0: secondary end masked
// - only mask-enabled bits reach the summary
// - primary error query returns and clears
// - primary end query returns and clears
// - event registers cannot be written externally
// - clear events on clear, power-on, mode switch
// - primary error mask written and read back
// - primary end mask written and read back
// - masks cleared by zero write, power-on, switch
// - secondary error query returns, clears; own mask
// - secondary end query returns, clears; own mask

module eesu_top #(
    parameter W = `EESU_EV_WIDTH
)(
    input  wire             clk,
    input  wire             reset,
    input  wire             native_mode,
    input  wire [4*W-1:0]   event_set,
    input  wire             clear_status_cmd,
    input  wire             mask_wr_cmd,
    input  wire [1:0]       mask_sel,
    input  wire [W-1:0]     mask_wdata,
    input  wire             query_req,
    input  wire [1:0]       query_sel,
    input  wire             query_mask,
    output reg              query_valid,
    output reg  [W-1:0]     query_data,
    output reg  [3:0]       extended_summary_bit
);

    // ----------------------------------------
    // set indexes, equal to summary bit numbers
    // ----------------------------------------
    localparam [1:0] SET_PRI_ERR = `EESU_SEL_PRI_ERR;
    localparam [1:0] SET_PRI_END = `EESU_SEL_PRI_END;
    localparam [1:0] SET_SEC_ERR = `EESU_SEL_SEC_ERR;
    localparam [1:0] SET_SEC_END = `EESU_SEL_SEC_END;

    // ----------------------------------------
    // selection decode
    // ----------------------------------------
    function sel_hit;
        input [1:0]  sel;
        input [31:0] idx;
        begin
            sel_hit = ({30'h0, sel} == idx);
        end
    endfunction

    // summary over all positions of one set
    function any_enabled;
        input [W-1:0] ev;
        input [W-1:0] mk;
        begin
            any_enabled = |(ev & mk);
        end
    endfunction

    // ----------------------------------------
    // language mode tracking
    // ----------------------------------------
    reg         mode_reg;
    wire        mode_switch;
    wire        active;

    // a switch in either direction wipes all state
    assign mode_switch = native_mode ^ mode_reg;
    assign active      = native_mode & ~mode_switch;

    // remembered mode gives the switch detector its past value
    wire        mode_next;
    assign mode_next = native_mode;

    always @(posedge clk)
    begin
        if (reset)
            mode_reg <= 1'h0;
        else
            mode_reg <= mode_next;
    end

    // ----------------------------------------
    // strobe decode, one bit per set
    // ----------------------------------------
    reg  [3:0]     rd_hit;
    reg  [3:0]     wr_hit;
    wire           clear_hit;
    integer        k;

    // clear-status touches events only, never masks
    assign clear_hit = clear_status_cmd & active;

    // a query of events clears; a mask query never does
    always @*
    begin
        rd_hit = 4'h0;
        wr_hit = 4'h0;
        for (k = 0; k < `EESU_SET_COUNT; k = k + 1)
        begin
            rd_hit[k] = query_req & ~query_mask & active & sel_hit(query_sel, k);
            wr_hit[k] = mask_wr_cmd & active & sel_hit(mask_sel, k);
        end
    end

    // ----------------------------------------
    // register sets, index = summary bit
    // ----------------------------------------
    wire [4*W-1:0] ev_flat;
    wire [4*W-1:0] mk_flat;
    wire [3:0]     sum_next;

    genvar g;
    generate
        for (g = 0; g < `EESU_SET_COUNT; g = g + 1)
        begin : g_set
            reg  [W-1:0] ev_reg;
            reg  [W-1:0] mk_reg;
            reg  [W-1:0] ev_next;
            reg  [W-1:0] mk_next;
            reg  [W-1:0] cap;
            wire         hit_rd;
            wire         hit_wr;
            wire         clr_ev;

            // only reset, the query path, clear-status, mode switch and capture touch events
            assign hit_rd = rd_hit[g];
            assign hit_wr = wr_hit[g];
            assign clr_ev = clear_hit | hit_rd;

            // events are dropped outside native mode
            always @*
            begin
                if (active)
                    cap = event_set[g*W +: W];
                else
                    cap = {W{1'h0}};
            end

            // new event wins over a clear in the same cycle
            always @*
            begin
                ev_next = ev_reg;
                if (mode_switch)
                    ev_next = {W{1'h0}};
                else
                begin
                    if (clr_ev)
                        ev_next = {W{1'h0}};
                    ev_next = ev_next | cap;
                end
            end

            // clear-status leaves masks alone; zero write clears
            always @*
            begin
                mk_next = mk_reg;
                if (mode_switch)
                    mk_next = {W{1'h0}};
                else if (hit_wr)
                    mk_next = mask_wdata;
            end

            // next values used so summary moves with registers
            assign sum_next[g] = any_enabled(ev_next, mk_next);

            assign ev_flat[g*W +: W] = ev_reg;
            assign mk_flat[g*W +: W] = mk_reg;

            always @(posedge clk)
            begin
                if (reset)
                begin
                    ev_reg <= `EESU_EV_RESET;
                    mk_reg <= `EESU_MASK_RESET;
                end
                else
                begin
                    ev_reg <= ev_next;
                    mk_reg <= mk_next;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // named views of the four sets
    // ----------------------------------------
    wire [W-1:0]   pri_err_events;
    wire [W-1:0]   pri_end_events;
    wire [W-1:0]   sec_err_events;
    wire [W-1:0]   sec_end_events;
    wire [W-1:0]   pri_err_mask;
    wire [W-1:0]   pri_end_mask;
    wire [W-1:0]   sec_err_mask;
    wire [W-1:0]   sec_end_mask;

    assign pri_err_events = ev_flat[SET_PRI_ERR*W +: W];
    assign pri_end_events = ev_flat[SET_PRI_END*W +: W];
    assign sec_err_events = ev_flat[SET_SEC_ERR*W +: W];
    assign sec_end_events = ev_flat[SET_SEC_END*W +: W];
    assign pri_err_mask   = mk_flat[SET_PRI_ERR*W +: W];
    assign pri_end_mask   = mk_flat[SET_PRI_END*W +: W];
    assign sec_err_mask   = mk_flat[SET_SEC_ERR*W +: W];
    assign sec_end_mask   = mk_flat[SET_SEC_END*W +: W];

    // ----------------------------------------
    // query read selection
    // ----------------------------------------
    reg  [W-1:0]   rd_events;
    reg  [W-1:0]   rd_mask;

    always @*
    begin
        rd_events = {W{1'h0}};
        rd_mask   = {W{1'h0}};
        case (query_sel)
            SET_PRI_ERR:
            begin
                rd_events = pri_err_events;
                rd_mask   = pri_err_mask;
            end
            SET_PRI_END:
            begin
                rd_events = pri_end_events;
                rd_mask   = pri_end_mask;
            end
            SET_SEC_ERR:
            begin
                rd_events = sec_err_events;
                rd_mask   = sec_err_mask;
            end
            SET_SEC_END:
            begin
                rd_events = sec_end_events;
                rd_mask   = sec_end_mask;
            end
            default:
            begin
                rd_events = {W{1'h0}};
                rd_mask   = {W{1'h0}};
            end
        endcase
    end

    // ----------------------------------------
    // output next values
    // ----------------------------------------
    reg  [W-1:0]   query_data_next;
    wire           query_valid_next;
    wire [3:0]     summary_next;

    // every query is answered, refused ones with zero
    assign query_valid_next = query_req;
    assign summary_next     = sum_next;

    // outside native mode a query answers zero
    always @*
    begin
        query_data_next = {W{1'h0}};
        if (query_req & active)
        begin
            if (query_mask)
                query_data_next = rd_mask;
            else
                query_data_next = rd_events;
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (reset)
            extended_summary_bit <= `EESU_SUM_RESET;
        else
            extended_summary_bit <= summary_next;
    end

    // answer stands one cycle for each cycle query_req is held, then returns to zero
    always @(posedge clk)
    begin
        if (reset)
        begin
            query_valid <= 1'h0;
            query_data  <= {W{1'h0}};
        end
        else
        begin
            query_valid <= query_valid_next;
            query_data  <= query_data_next;
        end
    end

endmodule

// [testbench/eesu_chk_assertions.sv]
`timescale 1ns/1ns
module eesu_chk #(parameter W = 8) (
    input wire clk, reset, native_mode, clear_status_cmd, mask_wr_cmd, query_req, query_valid,
    input wire [1:0] mask_sel,
    input wire [4*W-1:0] event_set,
    input wire [W-1:0] mask_wdata, query_data,
    input wire [3:0] extended_summary_bit
);
    wire [3:0] sb = extended_summary_bit;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_qv; query_req |=> query_valid; endproperty
    a_qv: assert property (p_qv) else $error("query not answered");
    property p_zd; !query_valid |-> query_data == 0; endproperty
    a_zd: assert property (p_zd) else $error("data outside answer");
    property p_ia; query_req && !native_mode |=> query_data == 0; endproperty
    a_ia: assert property (p_ia) else $error("answer while inactive");
    property p_sw; $changed(native_mode) |=> sb == 0; endproperty
    a_sw: assert property (p_sw) else $error("switch kept state");
    // same-cycle events win over the clear, so keep them out
    property p_cl; clear_status_cmd && native_mode && $stable(native_mode) && event_set == 0 |=> sb == 0; endproperty
    a_cl: assert property (p_cl) else $error("clear kept events");
    property p_mz; mask_wr_cmd && mask_wdata == 0 |=> !sb[$past(mask_sel)]; endproperty
    a_mz: assert property (p_mz) else $error("zero mask passes");
    property p_of; !native_mode |=> sb == 0; endproperty
    a_of: assert property (p_of) else $error("summary while inactive");
    property p_hd; event_set == 0 && !clear_status_cmd && !query_req && !mask_wr_cmd && $stable(native_mode) |=> $stable(sb); endproperty
    a_hd: assert property (p_hd) else $error("summary moved idle");
endmodule
bind eesu_top eesu_chk #(.W(W)) chk (
    .clk(clk),
    .reset(reset),
    .native_mode(native_mode),
    .clear_status_cmd(clear_status_cmd),
    .mask_wr_cmd(mask_wr_cmd),
    .query_req(query_req),
    .query_valid(query_valid),
    .mask_sel(mask_sel),
    .event_set(event_set),
    .mask_wdata(mask_wdata),
    .query_data(query_data),
    .extended_summary_bit(extended_summary_bit)
);

// [testbench/eesu_ctl.sv]
`timescale 1ns/1ns
module eesu_ctl (
    input wire clk,
    output reg clear_status_cmd = 0, mask_wr_cmd = 0, query_req = 0, query_mask = 0,
    output reg [1:0] mask_sel = 0, query_sel = 0,
    output reg [7:0] mask_wdata = 0
);
    // strobes drop after one edge so back-to-back calls never merge
    task cmd(input [2:0] k, input [1:0] s, input [7:0] d, input m);
        begin
            @(posedge clk) #1 {clear_status_cmd, mask_wr_cmd, query_req, mask_sel, query_sel, mask_wdata, query_mask} = {k, s, s, d, m};
            @(posedge clk) #1 {clear_status_cmd, mask_wr_cmd, query_req} = 3'h0;
        end
    endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    reg clk = 0, reset = 1, native_mode = 1;
    reg [31:0] event_set = 0;
    wire clear_status_cmd, mask_wr_cmd, query_req, query_mask, query_valid;
    wire [1:0] mask_sel, query_sel;
    wire [3:0] extended_summary_bit;
    wire [7:0] mask_wdata, query_data, sb = {4'h0, extended_summary_bit};
    integer err_count = 0, n_compared = 0, g;
    eesu_top dut (
        .clk(clk),
        .reset(reset),
        .native_mode(native_mode),
        .event_set(event_set),
        .clear_status_cmd(clear_status_cmd),
        .mask_wr_cmd(mask_wr_cmd),
        .mask_sel(mask_sel),
        .mask_wdata(mask_wdata),
        .query_req(query_req),
        .query_sel(query_sel),
        .query_mask(query_mask),
        .query_valid(query_valid),
        .query_data(query_data),
        .extended_summary_bit(extended_summary_bit)
    );
    eesu_ctl ctl (
        .clk(clk),
        .clear_status_cmd(clear_status_cmd),
        .mask_wr_cmd(mask_wr_cmd),
        .query_req(query_req),
        .query_mask(query_mask),
        .mask_sel(mask_sel),
        .query_sel(query_sel),
        .mask_wdata(mask_wdata)
    );
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) err_count = err_count + 1;
            if (got !== exp) $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        begin
            $display("mismatches %0d of %0d compares", err_count, n_compared);
            if (err_count == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial forever #5 clk = ~clk;
    initial
    begin
        repeat (5) @(posedge clk);
        #1 reset = 0;
        for (g = 0; g < 4; g = g + 1)
        begin
            ctl.cmd(3'h2, g, 8'h01, 1'h0);
            event_set = 32'h81 << 8 * g;
            ctl.cmd(3'h1, g, 8'h00, 1'h1);
            event_set = 0;
            chk(query_data, 8'h01);
            chk(sb, 8'((2 << g) - 1));
            chk({7'h0, query_valid}, 8'h01);
            chk({7'h0, |(sb & 8'h02)}, {7'h0, (g >= 1)});
        end
        for (g = 0; g < 4; g = g + 1)
        begin
            ctl.cmd(3'h1, g, 8'h00, 1'h0);
            chk(query_data, 8'h81);
        end
        chk(sb, 8'h00);
        event_set = 32'h8001_0000;
        ctl.cmd(3'h1, 2'h2, 8'h00, 1'h0);
        event_set = 0;
        chk(sb, 8'h04);
        ctl.cmd(3'h4, 2'h0, 8'h00, 1'h0);
        chk(sb, 8'h00);
        ctl.cmd(3'h1, 2'h2, 8'h00, 1'h1);
        chk(query_data, 8'h01);
        ctl.cmd(3'h2, 2'h2, 8'h00, 1'h0);
        native_mode = 0;
        ctl.cmd(3'h1, 2'h3, 8'h00, 1'h1);
        native_mode = 1;
        ctl.cmd(3'h1, 2'h3, 8'h00, 1'h1);
        chk(query_data, 8'h00);
        end_of_test;
    end
endmodule
